/* rtl/bhsc_params.svh */
// constants for the bus hold and snoop control block
`ifndef BHSC_PARAMS_SVH
`define BHSC_PARAMS_SVH
`define BHSC_SNOOP_LAT 2'h2
`define BHSC_DIRTY_TAIL 2'h2
`define BHSC_ADDR_W 29
`define BHSC_TAG_W 27
`define BHSC_NLINES 8
`define BHSC_IDX_W 3
`endif

/* rtl/bhsc_pkg.sv */
// types for the bus hold and snoop control block
`default_nettype none
package bhsc_pkg;
    typedef enum logic [1:0] {
        BHSC_ST_INV = 2'h0,
        BHSC_ST_SHR = 2'h1,
        BHSC_ST_EXC = 2'h3,
        BHSC_ST_MOD = 2'h2
    } bhsc_mesi_t;
    typedef enum logic [2:0] {
        BHSC_B_IDLE = 3'h0,
        BHSC_B_T1 = 3'h1,
        BHSC_B_T2 = 3'h3,
        BHSC_B_GRANT = 3'h2,
        BHSC_B_BACKOFF = 3'h6
    } bhsc_bus_t;
    typedef enum logic [1:0] {
        BHSC_S_IDLE = 2'h0,
        BHSC_S_LOOK = 2'h1,
        BHSC_S_WB = 2'h3,
        BHSC_S_TAIL = 2'h2
    } bhsc_snoop_t;
endpackage
`default_nettype wire

/* rtl/bhsc_line_store.sv */
// tag and line-state store with snoop look-up, fill and write policy update
`include "bhsc_params.svh"
`default_nettype none
module bhsc_line_store #(
    parameter int NLINES = `BHSC_NLINES,
    parameter int IDX_W = `BHSC_IDX_W,
    parameter int TAG_W = `BHSC_TAG_W
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [TAG_W-1:0] look_tag_i,
    output logic look_hit_o,
    output logic look_dirty_o,
    output logic [IDX_W-1:0] look_idx_o,
    input wire logic snoop_upd_i,
    input wire logic snoop_kill_i,
    input wire logic [IDX_W-1:0] snoop_idx_i,
    input wire logic fill_i,
    input wire logic [TAG_W-1:0] fill_tag_i,
    input wire logic write_i,
    input wire logic [TAG_W-1:0] write_tag_i,
    input wire logic policy_wb_i
);
    typedef struct packed {
        logic [NLINES-1:0][TAG_W-1:0] tag;
        bhsc_pkg::bhsc_mesi_t [NLINES-1:0] st;
        logic [IDX_W-1:0] victim;
    } bhsc_store_t;
    bhsc_store_t q;
    bhsc_store_t next_q;
    logic [NLINES-1:0] snp_m;
    logic [NLINES-1:0] wr_m;
    genvar g;
    generate
        for (g = 0; g < NLINES; g++) begin : g_cmp
            assign snp_m[g] = (q.st[g] != bhsc_pkg::BHSC_ST_INV) && (q.tag[g] == look_tag_i);
            assign wr_m[g] = (q.st[g] != bhsc_pkg::BHSC_ST_INV) && (q.tag[g] == write_tag_i);
        end
    endgenerate
    always_comb begin
        look_hit_o = |snp_m;
        look_idx_o = '0;
        look_dirty_o = 1'b0;
        for (int i = 0; i < NLINES; i++) begin
            if (snp_m[i]) begin
                look_idx_o = IDX_W'(i);
                look_dirty_o = (q.st[i] == bhsc_pkg::BHSC_ST_MOD);
            end
        end
    end
    always_comb begin
        next_q = q;
        if (fill_i) begin
            next_q.tag[q.victim] = fill_tag_i;
            next_q.st[q.victim] = policy_wb_i ? bhsc_pkg::BHSC_ST_EXC : bhsc_pkg::BHSC_ST_SHR;
            next_q.victim = q.victim + IDX_W'(1);
        end
        if (write_i) begin
            for (int i = 0; i < NLINES; i++) begin
                if (wr_m[i]) begin
                    if (q.st[i] == bhsc_pkg::BHSC_ST_SHR && policy_wb_i) begin
                        next_q.st[i] = bhsc_pkg::BHSC_ST_EXC;
                    end else if (q.st[i] == bhsc_pkg::BHSC_ST_EXC || q.st[i] == bhsc_pkg::BHSC_ST_MOD) begin
                        next_q.st[i] = bhsc_pkg::BHSC_ST_MOD;
                    end
                end
            end
        end
        // kill or share after a hit
        if (snoop_upd_i) begin
            next_q.st[snoop_idx_i] = snoop_kill_i ? bhsc_pkg::BHSC_ST_INV : bhsc_pkg::BHSC_ST_SHR;
        end
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end
endmodule
`default_nettype wire

/* rtl/bhsc_top.sv */
// bus hold, back-off and snoop control for the processor local bus
// Operation
// - fill or write hit goes write-back only with page attr 0 and policy 1.
// - write policy update touches only writes hitting a valid line.
// - back-off aborts the cycle and releases the bus next clock.
// - hold while back-off stays; afterwards rerun aborted cycle from start.
// - data offered while back-off is active is discarded.
// - start strobe may float while low when back-off hits with it.
// - pending output high while a cycle waits, in first clock and holds.
// - pending output drops in the data clocks of a cycle unless the cycle is locked and not a write-back.
// - takeover request: finish cycle or locked run, then float and grant same clock.
// - grant stays until request seen low or back-off; on request low regain bus same clock.
// - core keeps running from cache while bus is granted away.
// - bus hold floats bus outputs, keeps status outputs, ignores inputs except snoop inquiries and back-off.
// - address float request floats upper address and parity next clock.
// - under address float core misses may not start; snoop write-backs, back-off reruns and locked runs may.
// - snoop strobe triggers look-up, match, dirty report and write-back.
// - kill select high invalidates, low shares the hit line.
// - snoop match valid two clocks after strobe, held until next inquiry.
// - dirty valid two clocks after strobe, held to two after last ready.
// - inquiries accepted in address hold and full bus hold.
`include "bhsc_params.svh"
`default_nettype none
module bhsc_top #(
    parameter int ADDR_W = `BHSC_ADDR_W,
    parameter int TAG_W = `BHSC_TAG_W,
    parameter int NLINES = `BHSC_NLINES,
    parameter int IDX_W = `BHSC_IDX_W
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic abort_and_release_n_i,
    input wire logic takeover_request_i,
    input wire logic address_float_request_i,
    input wire logic snoop_address_strobe_n_i,
    input wire logic snoop_kill_select_i,
    input wire logic line_policy_select_i,
    input wire logic burst_ready_n_i,
    input wire logic [ADDR_W-1:0] address_i,
    input wire logic core_req_i,
    input wire logic core_write_i,
    input wire logic core_fill_i,
    input wire logic core_lock_i,
    input wire logic core_cache_hit_i,
    input wire logic core_page_wt_i,
    input wire logic [ADDR_W-1:0] core_addr_i,
    output logic core_stall_o,
    output logic core_done_o,
    output logic [ADDR_W-1:0] address_o,
    output logic address_oe_o,
    output logic address_parity_o,
    output logic ctrl_oe_o,
    output logic cycle_start_strobe_n_o,
    output logic cycle_start_strobe_oe_o,
    output logic write_o,
    output logic lock_n_o,
    output logic page_writethrough_attr_o,
    output logic pending_cycle_out_o,
    output logic takeover_grant_out_o,
    output logic snoop_match_n_o,
    output logic snoop_dirty_out_n_o
);
    // pin inputs pass two flops
    typedef struct packed {
        logic [1:0] abort_and_release_in;
        logic [1:0] hold;
        logic [1:0] address_float_request;
        logic [1:0] snoop_address_strobe;
        logic [1:0] snoop_kill_select;
        logic [1:0] wbwt;
        logic [1:0] rdy;
        logic [ADDR_W-1:0] a1;
        logic [ADDR_W-1:0] a2;
    } bhsc_sync_t;
    typedef struct packed {
        bhsc_pkg::bhsc_bus_t bus;
        bhsc_pkg::bhsc_snoop_t snp;
        logic [1:0] cnt;
        logic hit;
        logic dirty;
        logic kill;
        logic [IDX_W-1:0] idx;
        logic [ADDR_W-1:0] snp_addr;
        logic [ADDR_W-1:0] cyc_addr;
        logic cyc_write;
        logic cyc_fill;
        logic cyc_lock;
        logic cyc_wt;
        logic cyc_wb;
        logic done;
        logic address_float_request_d;
    } bhsc_state_t;
    bhsc_sync_t s;
    bhsc_sync_t next_s;
    bhsc_state_t q;
    bhsc_state_t next_q;
    logic abort_and_release_in;
    logic hold;
    logic address_float_request;
    logic snoop_address_strobe;
    logic rdy;
    logic look_hit;
    logic look_dirty;
    logic [IDX_W-1:0] look_idx;
    logic policy_wb;
    logic fill_now;
    logic write_now;
    logic waiting;

    // ==========================================================
    // input synchronisers
    always_comb begin
        next_s.abort_and_release_in = {s.abort_and_release_in[0], ~abort_and_release_n_i};
        next_s.hold = {s.hold[0], takeover_request_i};
        next_s.address_float_request = {s.address_float_request[0], address_float_request_i};
        next_s.snoop_address_strobe = {s.snoop_address_strobe[0], ~snoop_address_strobe_n_i};
        next_s.snoop_kill_select = {s.snoop_kill_select[0], snoop_kill_select_i};
        next_s.wbwt = {s.wbwt[0], line_policy_select_i};
        next_s.rdy = {s.rdy[0], ~burst_ready_n_i};
        next_s.a1 = address_i;
        next_s.a2 = s.a1;
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
    assign abort_and_release_in = s.abort_and_release_in[1];
    assign hold = s.hold[1];
    assign address_float_request = s.address_float_request[1];
    assign snoop_address_strobe = s.snoop_address_strobe[1];

    // ==========================================================
    // cache line store
    // write-back only when attr 0 and policy 1
    assign policy_wb = ~q.cyc_wt & s.wbwt[1];
    assign rdy = s.rdy[1] & ~abort_and_release_in & (q.bus == bhsc_pkg::BHSC_B_T2);
    assign fill_now = rdy & q.cyc_fill & ~q.cyc_wb;
    assign write_now = rdy & q.cyc_write & ~q.cyc_wb;

    bhsc_line_store #(
        .NLINES(NLINES),
        .IDX_W(IDX_W),
        .TAG_W(TAG_W)
    ) u_store (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .look_tag_i(q.snp_addr[ADDR_W-1 -: TAG_W]),
        .look_hit_o(look_hit),
        .look_dirty_o(look_dirty),
        .look_idx_o(look_idx),
        .snoop_upd_i(q.snp == bhsc_pkg::BHSC_S_LOOK && q.cnt == 2'h0 && look_hit),
        .snoop_kill_i(q.kill),
        .snoop_idx_i(look_idx),
        .fill_i(fill_now),
        .fill_tag_i(q.cyc_addr[ADDR_W-1 -: TAG_W]),
        .write_i(write_now),
        .write_tag_i(q.cyc_addr[ADDR_W-1 -: TAG_W]),
        .policy_wb_i(policy_wb)
    );

    // ==========================================================
    // bus and snoop sequencing
    always_comb begin
        next_q = q;
        next_q.done = 1'b0;
        next_q.address_float_request_d = address_float_request;
        case (q.snp)
            bhsc_pkg::BHSC_S_IDLE: begin
                if (snoop_address_strobe) begin
                    next_q.snp = bhsc_pkg::BHSC_S_LOOK;
                    next_q.snp_addr = s.a2;
                    next_q.kill = s.snoop_kill_select[1];
                    next_q.cnt = `BHSC_SNOOP_LAT - 2'h1;
                    next_q.hit = 1'b0;
                    next_q.dirty = 1'b0;
                end
            end
            bhsc_pkg::BHSC_S_LOOK: begin
                next_q.cnt = q.cnt - 2'h1;
                if (q.cnt == 2'h0) begin
                    next_q.hit = look_hit;
                    next_q.dirty = look_dirty;
                    next_q.snp = look_dirty ? bhsc_pkg::BHSC_S_WB : bhsc_pkg::BHSC_S_IDLE;
                end
            end
            bhsc_pkg::BHSC_S_WB: begin
                if (q.bus == bhsc_pkg::BHSC_B_T2 && q.cyc_wb && rdy) begin
                    next_q.snp = bhsc_pkg::BHSC_S_TAIL;
                    next_q.cnt = `BHSC_DIRTY_TAIL - 2'h1;
                end
            end
            bhsc_pkg::BHSC_S_TAIL: begin
                next_q.cnt = q.cnt - 2'h1;
                if (q.cnt == 2'h0) begin
                    next_q.dirty = 1'b0;
                    next_q.snp = bhsc_pkg::BHSC_S_IDLE;
                end
            end
            default: next_q.snp = bhsc_pkg::BHSC_S_IDLE;
        endcase
        case (q.bus)
            bhsc_pkg::BHSC_B_IDLE: begin
                if (abort_and_release_in) begin
                    next_q.bus = bhsc_pkg::BHSC_B_BACKOFF;
                end else if (hold) begin
                    next_q.bus = bhsc_pkg::BHSC_B_GRANT;
                end else if (q.snp == bhsc_pkg::BHSC_S_WB) begin
                    next_q.bus = bhsc_pkg::BHSC_B_T1;
                    next_q.cyc_wb = 1'b1;
                    next_q.cyc_addr = q.snp_addr;
                    next_q.cyc_write = 1'b1;
                    next_q.cyc_fill = 1'b0;
                    next_q.cyc_lock = 1'b0;
                    next_q.cyc_wt = 1'b0;
                // no new core miss cycles under address float
                end else if (core_req_i && !core_cache_hit_i && !address_float_request) begin
                    next_q.bus = bhsc_pkg::BHSC_B_T1;
                    next_q.cyc_wb = 1'b0;
                    next_q.cyc_addr = core_addr_i;
                    next_q.cyc_write = core_write_i;
                    next_q.cyc_fill = core_fill_i;
                    next_q.cyc_lock = core_lock_i;
                    next_q.cyc_wt = core_page_wt_i;
                end
            end
            bhsc_pkg::BHSC_B_T1: begin
                next_q.bus = abort_and_release_in ? bhsc_pkg::BHSC_B_BACKOFF : bhsc_pkg::BHSC_B_T2;
            end
            bhsc_pkg::BHSC_B_T2: begin
                if (abort_and_release_in) begin
                    next_q.bus = bhsc_pkg::BHSC_B_BACKOFF;
                end else if (rdy) begin
                    // finish cycle or locked run first
                    next_q.done = ~q.cyc_wb;
                    next_q.bus = (q.cyc_lock && core_req_i && core_lock_i) ? bhsc_pkg::BHSC_B_T1
                                                                           : bhsc_pkg::BHSC_B_IDLE;
                    if (next_q.bus == bhsc_pkg::BHSC_B_T1) begin
                        next_q.cyc_addr = core_addr_i;
                        next_q.cyc_write = core_write_i;
                        next_q.cyc_fill = core_fill_i;
                        next_q.cyc_lock = core_lock_i;
                        next_q.cyc_wt = core_page_wt_i;
                    end
                end
            end
            bhsc_pkg::BHSC_B_GRANT: begin
                // grant held until request seen low or back-off
                if (abort_and_release_in) begin
                    next_q.bus = bhsc_pkg::BHSC_B_BACKOFF;
                end else if (!hold) begin
                    next_q.bus = bhsc_pkg::BHSC_B_IDLE;
                end
            end
            bhsc_pkg::BHSC_B_BACKOFF: begin
                if (!abort_and_release_in) begin
                    next_q.bus = (q.cyc_addr != '0 || q.cyc_write || waiting) && q.done == 1'b0
                                 && (q.cyc_wb || core_req_i) ? bhsc_pkg::BHSC_B_T1 : bhsc_pkg::BHSC_B_IDLE;
                end
            end
            default: next_q.bus = bhsc_pkg::BHSC_B_IDLE;
        endcase
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    // ==========================================================
    // pin drive
    // core stalls only when it needs the bus
    assign waiting = (core_req_i && !core_cache_hit_i && !q.done) || q.snp == bhsc_pkg::BHSC_S_WB;
    assign core_stall_o = core_req_i & ~core_cache_hit_i & ~q.done;
    assign core_done_o = q.done;
    // pending in first clock and in holds
    // drop during data phase unless the cycle is locked and not a write-back
    assign pending_cycle_out_o = (q.bus == bhsc_pkg::BHSC_B_T1)
                                 || ((q.bus != bhsc_pkg::BHSC_B_T2) && waiting)
                                 || (q.bus == bhsc_pkg::BHSC_B_T2 && !q.cyc_wb && q.cyc_lock);
    assign takeover_grant_out_o = (q.bus == bhsc_pkg::BHSC_B_GRANT);
    assign ctrl_oe_o = (q.bus != bhsc_pkg::BHSC_B_GRANT) && (q.bus != bhsc_pkg::BHSC_B_BACKOFF);
    // upper address floats the clock after address float
    assign address_oe_o = ctrl_oe_o & ~q.address_float_request_d;
    assign address_o = q.cyc_addr;
    assign address_parity_o = ^q.cyc_addr;
    // strobe released at once on back-off, even while low
    assign cycle_start_strobe_n_o = ~(q.bus == bhsc_pkg::BHSC_B_T1);
    assign cycle_start_strobe_oe_o = ctrl_oe_o & ~abort_and_release_in;
    assign write_o = q.cyc_write;
    assign lock_n_o = ~q.cyc_lock;
    assign page_writethrough_attr_o = q.cyc_wt;
    assign snoop_match_n_o = ~q.hit;
    assign snoop_dirty_out_n_o = ~q.dirty;
endmodule
`default_nettype wire

/* tb/bhsc_checker.sv */
// assertion checker for the bus hold and snoop control block
`default_nettype none
module bhsc_checker (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic abort_and_release_n_i,
    input wire logic takeover_request_i,
    input wire logic address_float_request_i,
    input wire logic snoop_address_strobe_n_i,
    input wire logic burst_ready_n_i,
    input wire logic address_oe_o,
    input wire logic ctrl_oe_o,
    input wire logic cycle_start_strobe_n_o,
    input wire logic cycle_start_strobe_oe_o,
    input wire logic pending_cycle_out_o,
    input wire logic takeover_grant_out_o,
    input wire logic snoop_match_n_o,
    input wire logic snoop_dirty_out_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // cycle counters
    logic [3:0] since_strobe;
    logic [3:0] since_ready;
    // pins pass a two-flop sync, so answers are judged in a window, not on one edge
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            since_strobe <= 4'hF;
            since_ready <= 4'hF;
        end else begin
            since_strobe <= snoop_address_strobe_n_i ? since_strobe + {3'h0, since_strobe != 4'hF} : 4'h0;
            since_ready <= burst_ready_n_i ? since_ready + {3'h0, since_ready != 4'hF} : 4'h0;
        end
    end
    // ==========================================
    // properties
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    AST_ABORT_AND_RELEASE_IN_RELEASE: assert property (!abort_and_release_n_i [*4] |-> !ctrl_oe_o)
        else $error("bus still driven under back-off");
    AST_PEND_FIRST: assert property (!cycle_start_strobe_n_o && cycle_start_strobe_oe_o |-> pending_cycle_out_o)
        else $error("pending low in first clock of a cycle");
    AST_NO_GRANT_MIDCYCLE: assert property (!cycle_start_strobe_n_o |-> !takeover_grant_out_o)
        else $error("grant while a cycle starts");
    AST_GRANT_CAUSE: assert property ($rose(takeover_grant_out_o) |-> $past(takeover_request_i, 3))
        else $error("grant without a request");
    AST_GRANT_HOLD: assert property (takeover_request_i [*3] ##0 takeover_grant_out_o |=> takeover_grant_out_o)
        else $error("grant dropped while request held");
    AST_GRANT_REGAIN: assert property ($fell(takeover_grant_out_o) |-> ctrl_oe_o)
        else $error("bus not driven when grant drops");
    AST_GRANT_FLOATS: assert property (takeover_grant_out_o |-> !ctrl_oe_o && !address_oe_o)
        else $error("bus driven while granted away");
    AST_ADDRESS_FLOAT_REQUEST_FLOAT: assert property (address_float_request_i [*4] |-> !address_oe_o)
        else $error("address driven under address float");
    AST_ADDRESS_FLOAT_REQUEST_NOCYC: assert property (
        address_float_request_i [*4] ##0 $fell(cycle_start_strobe_n_o) |-> !snoop_dirty_out_n_o)
        else $error("new cycle under address float");
    AST_DIRTY_HIT: assert property (!snoop_dirty_out_n_o |-> !snoop_match_n_o)
        else $error("dirty without match");
    AST_MATCH_TIME: assert property (
        $changed(snoop_match_n_o) |-> since_strobe >= 4'h2 && since_strobe <= 4'h6)
        else $error("match moved outside an inquiry");
    AST_DIRTY_END: assert property (
        $rose(snoop_dirty_out_n_o) |-> since_ready >= 4'h2 && since_ready <= 4'h8)
        else $error("dirty released at wrong time");
endmodule
bind bhsc_top bhsc_checker i_bhsc_checker (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .abort_and_release_n_i(abort_and_release_n_i),
    .takeover_request_i(takeover_request_i), .address_float_request_i(address_float_request_i),
    .snoop_address_strobe_n_i(snoop_address_strobe_n_i), .burst_ready_n_i(burst_ready_n_i),
    .address_oe_o(address_oe_o), .ctrl_oe_o(ctrl_oe_o), .cycle_start_strobe_n_o(cycle_start_strobe_n_o),
    .cycle_start_strobe_oe_o(cycle_start_strobe_oe_o), .pending_cycle_out_o(pending_cycle_out_o),
    .takeover_grant_out_o(takeover_grant_out_o), .snoop_match_n_o(snoop_match_n_o),
    .snoop_dirty_out_n_o(snoop_dirty_out_n_o)
);
`default_nettype wire

/* tb/bhsc_bus_partner.sv */
// chipset model that answers each bus cycle after a set number of waits
`default_nettype none
module bhsc_bus_partner (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic start_n_i,
    input wire logic start_oe_i,
    input wire logic [3:0] wait_i,
    output logic ready_n_o = 1'h1
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    // ready is a one-clock pulse; the pulled-up line idles high between answers
    always @(negedge clk_i) begin
        ready_n_o <= !(rst_n_i === 1'h1 && cnt == 1);
        if (!rst_n_i) begin
            cnt = 0;
        end else if (cnt > 1) begin
            cnt = cnt - 1;
        end else if (cnt == 1) begin
            cnt = 0;
        end else if (start_n_i === 1'h0 && start_oe_i === 1'h1) begin
            cnt = int'(wait_i) + 1;
        end
    end
endmodule
`default_nettype wire

/* tb/tb_bhsc_top.sv */
// self-checking bench for the bus hold and snoop control block
`default_nettype none
module tb_bhsc_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int AW = 29;
    logic clk_i, rst_n_i = 1'h0, abort_and_release_in_n = 1'h1, treq = 1'h0, address_float_request = 1'h0, snoop_address_strobe_n = 1'h1, kill = 1'h0;
    logic pol = 1'h0, c_req = 1'h0, c_wr = 1'h0, c_fill = 1'h0, c_lock = 1'h0, c_hit = 1'h0, c_wt = 1'h0;
    logic rdy_n, stall, done, a_oe, c_oe, ads_n, ads_oe, pend, gnt, match_n, dirty_n, ap, wr_o, lk_n, pwt_o;
    logic [AW-1:0] snp_addr = '0, c_addr = '0, a, ao;
    logic [3:0] dly = 4'h0;
    int fails = 0, check_count = 0, starts = 0, dones = 0, s0, d0;
    bhsc_top i_bhsc_top (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .abort_and_release_n_i(abort_and_release_in_n), .takeover_request_i(treq),
        .address_float_request_i(address_float_request), .snoop_address_strobe_n_i(snoop_address_strobe_n), .snoop_kill_select_i(kill),
        .line_policy_select_i(pol), .burst_ready_n_i(rdy_n), .address_i(snp_addr), .core_req_i(c_req),
        .core_write_i(c_wr), .core_fill_i(c_fill), .core_lock_i(c_lock), .core_cache_hit_i(c_hit),
        .core_page_wt_i(c_wt), .core_addr_i(c_addr), .core_stall_o(stall), .core_done_o(done),
        .address_o(ao), .address_oe_o(a_oe), .address_parity_o(ap), .ctrl_oe_o(c_oe),
        .cycle_start_strobe_n_o(ads_n), .cycle_start_strobe_oe_o(ads_oe), .write_o(wr_o), .lock_n_o(lk_n),
        .page_writethrough_attr_o(pwt_o), .pending_cycle_out_o(pend), .takeover_grant_out_o(gnt),
        .snoop_match_n_o(match_n), .snoop_dirty_out_n_o(dirty_n)
    );
    bhsc_bus_partner i_bhsc_bus_partner (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .start_n_i(ads_n), .start_oe_i(ads_oe), .wait_i(dly), .ready_n_o(rdy_n)
    );
    initial begin
        clk_i = 1'h0;
        forever #20 clk_i = ~clk_i;
    end
    always @(negedge clk_i) begin
        if (ads_n === 1'h0 && ads_oe === 1'h1) starts++;
        if (done === 1'h1) dones++;
    end
    // ==========================================
    // helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        if (fails == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // write-back only for attr 0 and policy 1
    function automatic logic wb_line(input logic wt, input logic p);
        return !wt && p;
    endfunction
    function automatic logic [AW-1:0] rnd_addr();
        return AW'($urandom());
    endfunction
    function automatic logic pick(input int k);
        case (k)
            0: return done;
            1: return gnt;
            2: return dirty_n;
            default: return ads_n;
        endcase
    endfunction
    task automatic wait_on(input int k, input logic v);
        for (int n = 0; n < 300 && pick(k) !== v; n++) @(negedge clk_i);
        if (pick(k) !== v) begin
            chk(pick(k), v);
            stop_test();
        end
    endtask
    task automatic go(input logic wr, input logic fill, input logic wt, input logic hit, input logic [AW-1:0] ad);
        c_wr = wr;
        c_fill = fill;
        c_wt = wt;
        c_hit = hit;
        c_addr = ad;
        c_req = 1'h1;
    endtask
    task automatic finish_op();
        wait_on(0, 1'h1);
        c_req = 1'h0;
        @(negedge clk_i);
    endtask
    task automatic make_line(input logic [AW-1:0] ad, input logic wt);
        go(1'h0, 1'h1, wt, 1'h0, ad);
        finish_op();
        // bus write to the valid line
        go(1'h1, 1'h0, wt, 1'h0, ad);
        finish_op();
    endtask
    task automatic snoop(input logic [AW-1:0] ad, input logic k, input logic hit, input logic dirty);
        // address and kill ride with the strobe
        snp_addr = ad;
        kill = k;
        snoop_address_strobe_n = 1'h0;
        @(negedge clk_i);
        snoop_address_strobe_n = 1'h1;
        snp_addr = ~ad;
        kill = ~k;
        repeat (5) @(negedge clk_i);
        chk(match_n, !hit);
        chk(dirty_n, !dirty);
        wait_on(2, 1'h1);
    endtask
    // ==========================================
    // scenarios
    initial begin
        void'($urandom(32'h6fcc29f4));
        repeat (2) @(negedge clk_i);
        chk({gnt, match_n, dirty_n, ads_n, c_oe, a_oe}, 6'h1F);
        rst_n_i = 1'h1;
        repeat (3) @(negedge clk_i);
        for (int i = 0; i < 8; i++) begin
            a = rnd_addr();
            dly = 4'($urandom_range(5));
            pol = i[0];
            make_line(a, i[1]);
            snoop(a, i[2], 1'h1, wb_line(i[1], i[0]));
            snoop(a, 1'h0, !i[2], 1'h0);
        end
        a = rnd_addr();
        go(1'h1, 1'h0, 1'h0, 1'h0, a);
        finish_op();
        snoop(a, 1'h0, 1'h0, 1'h0);
        dly = 4'hA;
        s0 = starts;
        d0 = dones;
        go(1'h0, 1'h0, 1'h0, 1'h0, rnd_addr());
        wait_on(3, 1'h0);
        abort_and_release_in_n = 1'h0;
        repeat (14) @(negedge clk_i);
        chk(dones - d0, 0);
        abort_and_release_in_n = 1'h1;
        finish_op();
        chk(starts - s0, 2);
        dly = 4'h6;
        d0 = dones;
        a = rnd_addr();
        go(1'h0, 1'h0, 1'h0, 1'h0, a);
        wait_on(3, 1'h0);
        treq = 1'h1;
        chk(ao, a);
        chk({ap, wr_o, lk_n, pwt_o}, {^a, 3'h2});
        @(negedge clk_i);
        chk(pend, 1'h0);
        finish_op();
        wait_on(1, 1'h1);
        chk(dones - d0, 1);
        chk({c_oe, a_oe, ads_oe}, 3'h0);
        go(1'h0, 1'h0, 1'h0, 1'h1, rnd_addr());
        @(negedge clk_i);
        chk(stall, 1'h0);
        c_req = 1'h0;
        @(negedge clk_i);
        go(1'h0, 1'h0, 1'h0, 1'h0, rnd_addr());
        repeat (4) @(negedge clk_i);
        chk({stall, gnt}, 2'h3);
        treq = 1'h0;
        wait_on(1, 1'h0);
        chk(c_oe, 1'h1);
        finish_op();
        a = rnd_addr();
        pol = 1'h1;
        make_line(a, 1'h0);
        address_float_request = 1'h1;
        repeat (4) @(negedge clk_i);
        chk(a_oe, 1'h0);
        s0 = starts;
        go(1'h0, 1'h0, 1'h0, 1'h0, rnd_addr());
        repeat (4) @(negedge clk_i);
        chk(pend, 1'h1);
        snoop(a, 1'h1, 1'h1, 1'h1);
        chk(starts - s0, 1);
        address_float_request = 1'h0;
        finish_op();
        chk(starts - s0, 2);
        stop_test();
    end
endmodule
`default_nettype wire
